//--- cmd_decoder.sv
// bus interface message decoder: splits command bytes from device messages
// assumes bytes arrive from an acceptor handshake on clk, one strobe per byte,
// and that listener addressing is tracked elsewhere on the same clock
//
// Contract
// - codes 10h-1Fh act regardless of addressing
// - codes 00h-0Fh act only when listener addressed
// - device clear aborts parser, keeps settings
// - interface clear resets interface state machines
// - lockout disables local return key
// - serial poll enable enters, disable leaves
// - unconfigure leaves parallel poll configured state
// - trigger command pulses device trigger
// - go to local returns to manual control
// - configure accepts following enable/disable byte
// - attention released bytes go to parser
// - decode commands only while attention low
`timescale 1ns/1ns
`default_nettype none

module cmd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus pins and local return key, active low, asynchronous to clk
  input wire logic atn_n,
  input wire logic ifc_n,
  input wire logic local_return_key_n,
  // from acceptor handshake and address recognition
  input wire cmd_decode_pkg::bus_byte_t rx_byte,
  input wire logic listen_addressed,
  // towards command parser
  output cmd_decode_pkg::dev_msg_t dev_msg,
  output logic parser_clear,
  // instrument control effects
  output logic device_trigger,
  output logic go_local,
  output logic local_request,
  output logic lockout,
  output logic iface_clear,
  // poll state
  output logic serial_poll,
  output cmd_decode_pkg::pp_cfg_t pp_cfg
);

  typedef enum logic {
    ST_IDLE,
    ST_PP_SECONDARY
  } pp_state_t;

  logic atn_n_s;
  logic ifc_n_s;
  logic key_n_s;
  logic key_n_prev_q;
  logic [6:0] code;
  logic [2:0] group;
  logic cmd_stb;
  logic is_uni;
  logic is_addr;
  pp_state_t pp_state_q;
  pp_state_t pp_state_d;

  // field positions, declared before any slice that uses them
  localparam int GROUP_MSB_L = cmd_decode_pkg::GROUP_MSB;
  localparam int GROUP_LSB_L = cmd_decode_pkg::GROUP_LSB;
  localparam int SEC_MSB_L = cmd_decode_pkg::SEC_MSB;
  localparam int SEC_LSB_L = cmd_decode_pkg::SEC_LSB;
  localparam int SEC_LINE_MSB_L = cmd_decode_pkg::SEC_LINE_MSB;
  localparam int SEC_LINE_LSB_L = cmd_decode_pkg::SEC_LINE_LSB;

  // pins pass two flops before any decode looks at them
  sync_2ff #(
    .WIDTH(3),
    .RST_VAL(3'h7)
  ) i_sync_2ff (
    .clk(clk),
    .resetn(resetn),
    .async_in({atn_n, ifc_n, local_return_key_n}),
    .sync_out({atn_n_s, ifc_n_s, key_n_s})
  );

  // true when a command byte matches an addressed or universal code
  function automatic logic hit(input logic [6:0] c, input logic [6:0] ref_code);
    hit = (c == ref_code);
  endfunction : hit

  assign code = rx_byte.data[6:0];
  assign group = rx_byte.data[GROUP_MSB_L:GROUP_LSB_L];

  assign cmd_stb = rx_byte.valid && !atn_n_s && ifc_n_s;
  assign is_uni = cmd_stb && (group == cmd_decode_pkg::GROUP_UNIVERSAL);
  assign is_addr = cmd_stb && (group == cmd_decode_pkg::GROUP_ADDRESSED) && listen_addressed;

  // interface clear is a level seen after synchronisation
  // interface clear level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      iface_clear <= 1'b0;
    end else begin
      iface_clear <= !ifc_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dev_msg.valid <= 1'b0;
      dev_msg.data <= cmd_decode_pkg::MSG_DATA_RST;
    end else begin
      dev_msg.valid <= rx_byte.valid && atn_n_s;
      if (rx_byte.valid && atn_n_s) begin
        dev_msg.data <= rx_byte.data;
      end
    end
  end

  // clear from universal or selected clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      parser_clear <= 1'b0;
    end else begin
      parser_clear <= (is_uni && hit(code, cmd_decode_pkg::UCMD_DEV_CLEAR)) ||
                      (is_addr && hit(code, cmd_decode_pkg::ACMD_SEL_CLEAR));
    end
  end

  // trigger pulse, same as external trigger
  always_ff @(posedge clk) begin
    if (!resetn) begin
      device_trigger <= 1'b0;
    end else begin
      device_trigger <= is_addr && hit(code, cmd_decode_pkg::ACMD_TRIGGER);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      go_local <= 1'b0;
    end else begin
      go_local <= is_addr && hit(code, cmd_decode_pkg::ACMD_GO_LOCAL);
    end
  end

  // lockout is sticky; only reset removes it, since releasing it belongs
  // to remote enable handling outside this block
  // lockout latch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lockout <= 1'b0;
    end else if (is_uni && hit(code, cmd_decode_pkg::UCMD_LOCKOUT)) begin
      lockout <= 1'b1;
    end
  end

  // key press edge, suppressed while locked out
  always_ff @(posedge clk) begin
    if (!resetn) begin
      key_n_prev_q <= 1'b1;
    end else begin
      key_n_prev_q <= key_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      local_request <= 1'b0;
    end else begin
      local_request <= key_n_prev_q && !key_n_s && !lockout;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_poll <= 1'b0;
    end else if (!ifc_n_s) begin
      serial_poll <= 1'b0; // interface clear returns to idle
    end else if (is_uni && hit(code, cmd_decode_pkg::UCMD_SPOLL_ON)) begin
      serial_poll <= 1'b1;
    end else if (is_uni && hit(code, cmd_decode_pkg::UCMD_SPOLL_OFF)) begin
      serial_poll <= 1'b0;
    end
  end

  // configure waits for the next command byte; any other command byte drops the wait,
  // so a stray secondary later on cannot reconfigure the response
  // secondary byte sequencing
  always_comb begin
    pp_state_d = pp_state_q;
    case (pp_state_q)
      ST_IDLE: begin
        if (is_addr && hit(code, cmd_decode_pkg::ACMD_PP_CONFIG)) begin
          pp_state_d = ST_PP_SECONDARY;
        end
      end
      ST_PP_SECONDARY: begin
        if (cmd_stb) begin
          pp_state_d = ST_IDLE;
        end
      end
      default: pp_state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn || !ifc_n_s) begin
      pp_state_q <= ST_IDLE;
    end else begin
      pp_state_q <= pp_state_d;
    end
  end

  // response setting: enable byte stores sense and line, disable byte drops it
  // apply enable or disable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pp_cfg.configured <= 1'b0;
      pp_cfg.sense <= cmd_decode_pkg::PP_SENSE_RST;
      pp_cfg.line <= cmd_decode_pkg::PP_LINE_RST;
    end else if (is_uni && hit(code, cmd_decode_pkg::UCMD_PP_UNCONFIG)) begin
      pp_cfg.configured <= 1'b0;
    end else if (pp_state_q == ST_PP_SECONDARY && cmd_stb &&
                 rx_byte.data[SEC_MSB_L:SEC_LSB_L] == cmd_decode_pkg::SEC_GROUP) begin
      if (rx_byte.data[cmd_decode_pkg::SEC_DISABLE_BIT]) begin
        pp_cfg.configured <= 1'b0;
      end else begin
        pp_cfg.configured <= 1'b1;
        pp_cfg.sense <= rx_byte.data[cmd_decode_pkg::SEC_SENSE_BIT];
        pp_cfg.line <= rx_byte.data[SEC_LINE_MSB_L:SEC_LINE_LSB_L];
      end
    end
  end

endmodule : cmd_decoder

`default_nettype wire

//--- cmd_decode_pkg.sv
// package for the bus interface message decoder
// shared codes, field positions, reset values and carrier structs
package cmd_decode_pkg;

  // universal command codes, seven significant bits
  localparam logic [6:0] UCMD_LOCKOUT = 7'h11;
  localparam logic [6:0] UCMD_DEV_CLEAR = 7'h14;
  localparam logic [6:0] UCMD_PP_UNCONFIG = 7'h15;
  localparam logic [6:0] UCMD_SPOLL_ON = 7'h18;
  localparam logic [6:0] UCMD_SPOLL_OFF = 7'h19;

  // addressed command codes
  localparam logic [6:0] ACMD_GO_LOCAL = 7'h01;
  localparam logic [6:0] ACMD_SEL_CLEAR = 7'h04;
  localparam logic [6:0] ACMD_PP_CONFIG = 7'h05;
  localparam logic [6:0] ACMD_TRIGGER = 7'h08;

  // command group field: bits 6..4 of the byte
  localparam int GROUP_MSB = 6;
  localparam int GROUP_LSB = 4;
  localparam logic [2:0] GROUP_ADDRESSED = 3'h0;
  localparam logic [2:0] GROUP_UNIVERSAL = 3'h1;

  // secondary byte following a configure: 11x_xxxx, bit 4 picks enable or disable
  localparam int SEC_MSB = 6;
  localparam int SEC_LSB = 5;
  localparam logic [1:0] SEC_GROUP = 2'h3;
  localparam int SEC_DISABLE_BIT = 4;
  localparam int SEC_SENSE_BIT = 3;
  localparam int SEC_LINE_MSB = 2;
  localparam int SEC_LINE_LSB = 0;

  // reset values
  localparam logic [2:0] PP_LINE_RST = 3'h0;
  localparam logic PP_SENSE_RST = 1'b0;
  localparam logic [7:0] MSG_DATA_RST = 8'h00;

  // byte delivered by the acceptor handshake
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bus_byte_t;

  // parallel poll response setting
  typedef struct packed {
    logic configured;
    logic sense;
    logic [2:0] line;
  } pp_cfg_t;

  // device message towards the command parser
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dev_msg_t;

endpackage : cmd_decode_pkg

//--- sync_2ff.sv
// two flip-flop synchroniser for pin levels
// assumes the inputs are slow levels; no data word goes through here
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sync_2ff

`default_nettype wire

//--- cmd_decoder_props.sv
// checker for the interface message decoder, bound to its ports
// assumes pins pass two sync flops; the synced copies are rebuilt here
`timescale 1ns/1ns
`default_nettype none
module cmd_decoder_props (
  // clock, reset and pins
  input wire logic clk,
  input wire logic resetn,
  input wire logic atn_n,
  input wire logic ifc_n,
  input wire logic local_return_key_n,
  // byte side
  input wire cmd_decode_pkg::bus_byte_t rx_byte,
  input wire logic listen_addressed,
  // effects
  input wire cmd_decode_pkg::dev_msg_t dev_msg,
  input wire logic parser_clear,
  input wire logic device_trigger,
  input wire logic go_local,
  input wire logic local_request,
  input wire logic lockout,
  input wire logic iface_clear,
  input wire logic serial_poll,
  input wire cmd_decode_pkg::pp_cfg_t pp_cfg
);
  logic [1:0] a_s;
  logic [1:0] i_s;
  // mirror the synchronisers so a byte is judged by the same pin view
  always_ff @(posedge clk) begin
    if (!resetn) begin
      a_s <= 2'h3;
      i_s <= 2'h3;
    end else begin
      a_s <= {a_s[0], atn_n};
      i_s <= {i_s[0], ifc_n};
    end
  end
  wire logic cmd = rx_byte.valid && !a_s[1] && i_s[1];
  wire logic [6:0] op = rx_byte.data[6:0];
  wire logic lis = listen_addressed;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_spoll_enter: assert property (cmd && op == 7'h18 |=> serial_poll)
    else $error("serial poll not entered");
  chk_spoll_leave: assert property (cmd && op == 7'h19 |=> !serial_poll)
    else $error("serial poll not left");
  chk_lockout_set: assert property (cmd && op == 7'h11 |=> lockout)
    else $error("lockout not set");
  chk_clear_pulse: assert property (
    cmd && (op == 7'h14 || (op == 7'h04 && lis)) |=> parser_clear)
    else $error("parser clear missing");
  chk_trig_cause: assert property (device_trigger |-> $past(cmd && op == 7'h08 && lis))
    else $error("trigger without addressed command");
  chk_local_cause: assert property (go_local |-> $past(cmd && op == 7'h01 && lis))
    else $error("go local without addressed command");
  chk_pp_unconf: assert property (cmd && op == 7'h15 |=> !pp_cfg.configured)
    else $error("unconfigure ignored");
  // bytes arrive with one idle cycle between strobes, as the controller sends them
  chk_pp_enable: assert property (
    (cmd && op == 7'h05 && lis) ##1 (!cmd && i_s[1]) ##1 (cmd && op[6:4] == 3'h6)
    |=> pp_cfg == {1'b1, $past(rx_byte.data[3:0])})
    else $error("poll response not set");
  chk_pp_disable: assert property (
    (cmd && op == 7'h05 && lis) ##1 (!cmd && i_s[1]) ##1 (cmd && op[6:4] == 3'h7)
    |=> !pp_cfg.configured)
    else $error("poll response not dropped");
  chk_msg_pass: assert property (rx_byte.valid && a_s[1]
    |=> dev_msg.valid && dev_msg.data == $past(rx_byte.data))
    else $error("device message not forwarded");
  chk_iface_level: assert property (iface_clear == !$past(i_s[1]))
    else $error("interface clear level wrong");
endmodule : cmd_decoder_props
bind cmd_decoder cmd_decoder_props i_props (
  .clk(clk), .resetn(resetn), .atn_n(atn_n), .ifc_n(ifc_n),
  .local_return_key_n(local_return_key_n), .rx_byte(rx_byte),
  .listen_addressed(listen_addressed), .dev_msg(dev_msg), .parser_clear(parser_clear),
  .device_trigger(device_trigger), .go_local(go_local), .local_request(local_request),
  .lockout(lockout), .iface_clear(iface_clear), .serial_poll(serial_poll), .pp_cfg(pp_cfg)
);
`default_nettype wire

//--- cmd_ctrl_model.sv
// bus controller model: attention, interface clear and byte strobes
// assumes the bench calls its tasks at the falling edge
`timescale 1ns/1ns
`default_nettype none
module cmd_ctrl_model (
  // clock
  input wire logic clk,
  // bus side
  output logic atn_n,
  output logic ifc_n,
  output cmd_decode_pkg::bus_byte_t rx_byte
);
  initial begin
    atn_n = 1'b1;
    ifc_n = 1'b1;
    rx_byte = '0;
  end
  // pin levels, then time for the synchronisers
  task automatic pins(input logic a, input logic i);
    @(negedge clk);
    atn_n = a;
    ifc_n = i;
    repeat (4) @(negedge clk);
  endtask : pins
  // inverse data after the strobe so a stale byte is never mistaken
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    rx_byte = {1'b1, b};
    @(negedge clk);
    rx_byte = {1'b0, ~b};
  endtask : send
endmodule : cmd_ctrl_model
`default_nettype wire

//--- test_gpib_interface_message_decoder.sv
// testbench for the interface message decoder
// assumes the controller model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_gpib_interface_message_decoder;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic key_n = 1'b1;
  logic listen = 1'b0;
  wire logic atn_n;
  wire logic ifc_n;
  cmd_decode_pkg::bus_byte_t rx_byte;
  cmd_decode_pkg::dev_msg_t dev_msg;
  cmd_decode_pkg::pp_cfg_t pp_cfg;
  logic clr, trig, loc, req, lockout, ifc, spoll;
  int err_count = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  cmd_ctrl_model i_cmd_ctrl_model (.clk(clk), .atn_n(atn_n), .ifc_n(ifc_n), .rx_byte(rx_byte));
  cmd_decoder i_cmd_decoder (
    .clk(clk), .resetn(resetn), .atn_n(atn_n), .ifc_n(ifc_n), .local_return_key_n(key_n),
    .rx_byte(rx_byte), .listen_addressed(listen), .dev_msg(dev_msg), .parser_clear(clr),
    .device_trigger(trig), .go_local(loc), .local_request(req), .lockout(lockout),
    .iface_clear(ifc), .serial_poll(spoll), .pp_cfg(pp_cfg)
  );
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: bit %b", $time, got);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: value %h", $time, got);
    end
  endtask : chk_val
  task automatic tx(input logic [7:0] b);
    i_cmd_ctrl_model.send(b);
  endtask : tx
  // counts return pulses over a press; sync lag is well inside 8 cycles
  task automatic key_press(output int n);
    n = 0;
    @(negedge clk);
    key_n = 1'b0;
    repeat (8) @(negedge clk) n += int'(req);
    key_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : key_press
  task automatic t_universal;
    int n;
    key_press(n);
    chk_val(9'(n), 9'h001);
    i_cmd_ctrl_model.pins(1'b0, 1'b1);
    tx(8'h18);
    chk_bit(spoll, 1'b1);
    tx(8'h99);
    chk_bit(spoll, 1'b0);
    tx(8'h14);
    chk_bit(clr, 1'b1);
    tx(8'h11);
    chk_bit(lockout, 1'b1);
    key_press(n);
    chk_val(9'(n), 9'h000);
  endtask : t_universal
  task automatic t_addressed;
    tx(8'h08);
    chk_bit(trig, 1'b0);
    tx(8'h04);
    chk_bit(clr, 1'b0);
    listen = 1'b1;
    tx(8'h08);
    chk_bit(trig, 1'b1);
    tx(8'h01);
    chk_bit(loc, 1'b1);
    tx(8'h04);
    chk_bit(clr, 1'b1);
    tx(8'h05);
    tx(8'h6d);
    chk_val(9'(pp_cfg), 9'h01d);
    tx(8'h05);
    tx(8'h70);
    chk_bit(pp_cfg.configured, 1'b0);
    tx(8'h05);
    tx(8'h62);
    chk_val(9'(pp_cfg), 9'h012);
    tx(8'h15);
    chk_bit(pp_cfg.configured, 1'b0);
  endtask : t_addressed
  task automatic t_message;
    i_cmd_ctrl_model.pins(1'b1, 1'b1);
    tx(8'h18);
    chk_val(dev_msg, 9'h118);
    chk_bit(spoll, 1'b0);
    i_cmd_ctrl_model.pins(1'b0, 1'b1);
    tx(8'h18);
    chk_bit(dev_msg.valid, 1'b0);
    i_cmd_ctrl_model.pins(1'b0, 1'b0);
    chk_bit(ifc, 1'b1);
    chk_bit(spoll, 1'b0);
    i_cmd_ctrl_model.pins(1'b0, 1'b1);
    chk_bit(ifc, 1'b0);
  endtask : t_message
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // watchdog: the tests take under a hundred cycles
  initial begin
    #(3000 * 100);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_universal();
    t_addressed();
    t_message();
    give_verdict();
  end
endmodule : test_gpib_interface_message_decoder
`default_nettype wire
